// ===== hdl/tcc_port_ctrl.sv
// port-role controller configuration block reached as an i2c target
`timescale 1ns/1ps

module tcc_port_ctrl #(
  parameter logic [5:0] ADDR_HIGH   = 6'h1d,  // upper address bits
  parameter logic [7:0] FIRST_VALUE = 8'h00   // arbitrary register 1 value
) (
  input  wire logic                   core_clk_in,         // 125 mhz clock
  input  wire logic                   reset_in,            // power-on reset
  input  wire logic                   scl_in,              // i2c clock pin
  input  wire logic                   sda_in,              // i2c data pin
  output logic                        sda_out,             // sda drive level
  output logic                        sda_oe_n_out,        // low: drive sda
  input  wire logic                   chip_disable_pin,    // high disables
  input  wire logic [1:0]             role_strap_in,       // role strap pin
  input  wire logic                   addr_strap_in,       // address strap
  input  wire logic [7:0]             event_set_in,        // event pulses
  input  wire logic [7:0]             cc_status_in,        // cc status code
  output logic                        interrupt_request_out, // int level
  output logic                        interrupt_oe_n_out,  // low: pull int
  output logic                        attach_indicator_out, // low on sink
  output logic                        detect_enable_out,   // monitor cc/vbus
  output tcc_pkg::tcc_port_cfg_t      port_cfg_out         // port config
);
  import tcc_pkg::*;

  // ==========================================================================
  // pin synchronisation
  logic [TCC_SYNC_WIDTH-1:0] pins_sync;
  logic                      scl_s;
  logic                      sda_s;
  logic                      dis_s;
  logic [1:0]                strap_s;
  logic                      addr_s;

  tcc_sync #(
    .WIDTH (TCC_SYNC_WIDTH)
  ) u_sync (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .async_in    ({scl_in, sda_in, chip_disable_pin, role_strap_in,
                   addr_strap_in}),
    .sync_out    (pins_sync)
  );

  assign scl_s   = pins_sync[5];
  assign sda_s   = pins_sync[4];
  assign dis_s   = pins_sync[3];
  assign strap_s = pins_sync[2:1];
  assign addr_s  = pins_sync[0];

  // ==========================================================================
  // bus condition detection
  logic scl_q_r;
  logic sda_q_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_s;
      sda_q_r <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_q_r;
  assign scl_fall  = ~scl_s & scl_q_r;
  assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
  assign stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;

  // ==========================================================================
  // i2c target state machine
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WDATA,
    ST_WACK,
    ST_RDATA,
    ST_RACK
  } tcc_state_t;

  tcc_state_t  state_r;
  logic [7:0]  shift_r;
  logic [3:0]  bit_cnt_r;
  logic [2:0]  ptr_r;
  logic        rw_r;
  logic [6:0]  own_addr;
  logic [7:0]  rd_byte;
  logic        wr_fire;
  logic        rd_load;
  tcc_ctrl_t   ctrl_r;
  logic [7:0]  event_r;
  logic [7:0]  event_seen_r;
  logic        first_done_r;
  logic [1:0]  settle_r;

  assign own_addr = {ADDR_HIGH, addr_s};

  // register read mux, beyond the last register reads zero
  always_comb begin
    case (ptr_r)
      TCC_REG_FIRST:  rd_byte = FIRST_VALUE;
      TCC_REG_CTRL:   rd_byte = ctrl_r;
      TCC_REG_EVENT:  rd_byte = event_r;
      TCC_REG_STATUS: rd_byte = cc_status_in;
      default:        rd_byte = 8'h00;
    endcase
  end

  assign wr_fire = (state_r == ST_WDATA) && scl_fall &&
                   (bit_cnt_r == TCC_BITS_PER_BYTE);
  assign rd_load = scl_fall && ((state_r == ST_ADDR_ACK && rw_r) ||
                   (state_r == ST_RACK));

  // the target keeps running in every disabled state
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_r      <= ST_IDLE;
      shift_r      <= 8'h00;
      bit_cnt_r    <= 4'h0;
      ptr_r        <= TCC_REG_FIRST;
      rw_r         <= 1'b0;
      sda_oe_n_out <= 1'b1;
    end else if (start_det) begin
      state_r      <= ST_ADDR;
      bit_cnt_r    <= 4'h0;
      ptr_r        <= TCC_REG_FIRST;
      sda_oe_n_out <= 1'b1;
    end else if (stop_det) begin
      state_r      <= ST_IDLE;
      sda_oe_n_out <= 1'b1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          sda_oe_n_out <= 1'b1;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == TCC_BITS_PER_BYTE) begin
            if (shift_r[7:1] == own_addr) begin
              rw_r         <= shift_r[0];
              sda_oe_n_out <= 1'b0;
              state_r      <= ST_ADDR_ACK;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              shift_r      <= rd_byte;
              sda_oe_n_out <= rd_byte[7];
              bit_cnt_r    <= 4'h1;
              state_r      <= ST_RDATA;
            end else begin
              sda_oe_n_out <= 1'b1;
              bit_cnt_r    <= 4'h0;
              state_r      <= ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            shift_r   <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (wr_fire) begin
            sda_oe_n_out <= 1'b0;
            state_r      <= ST_WACK;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            sda_oe_n_out <= 1'b1;
            bit_cnt_r    <= 4'h0;
            if (ptr_r != TCC_REG_BEYOND) begin
              ptr_r <= ptr_r + 3'h1;
            end
            state_r <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_r == TCC_BITS_PER_BYTE) begin
              sda_oe_n_out <= 1'b1;
              state_r      <= ST_RACK;
              if (ptr_r != TCC_REG_BEYOND) begin
                ptr_r <= ptr_r + 3'h1;
              end
            end else begin
              shift_r      <= {shift_r[6:0], 1'b0};
              sda_oe_n_out <= shift_r[6];
              bit_cnt_r    <= bit_cnt_r + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s) begin
            state_r <= ST_IDLE;  // nack ends the read
          end else if (scl_fall) begin
            shift_r      <= rd_byte;
            sda_oe_n_out <= rd_byte[7];
            bit_cnt_r    <= 4'h1;
            state_r      <= ST_RDATA;
          end
        end
        default: begin
          state_r      <= ST_IDLE;
          sda_oe_n_out <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // control register
  // a host write wins over the strap load in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ctrl_r       <= TCC_CTRL_RESET;
      first_done_r <= 1'b0;
      settle_r     <= 2'b00;
    end else begin
      // sync flops hold reset zeros for two edges, not the real straps
      settle_r <= {settle_r[0], 1'b1};
      if (wr_fire && ptr_r == TCC_REG_CTRL) begin
        ctrl_r <= shift_r;
      end else if (!first_done_r && !dis_s && settle_r[1]) begin
        ctrl_r.role <= strap_s;
      end
      if (!dis_s && settle_r[1]) begin
        first_done_r <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // event flags, cleared only for bits actually shifted out
  logic [7:0] event_clr;

  assign event_clr = (state_r == ST_RDATA && scl_fall &&
                      bit_cnt_r == TCC_BITS_PER_BYTE &&
                      ptr_r == TCC_REG_EVENT) ? event_seen_r : 8'h00;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      event_r      <= 8'h00;
      event_seen_r <= 8'h00;
    end else begin
      if (rd_load && ptr_r == TCC_REG_EVENT) begin
        event_seen_r <= event_r;
      end
      // set wins over clear so no event is lost
      event_r <= (event_r & ~event_clr) | event_set_in;
    end
  end

  // ==========================================================================
  // port configuration decode
  logic          port_active;
  tcc_port_cfg_t cfg_nxt;

  assign port_active = ~dis_s & ~ctrl_r.save & settle_r[1];

  always_comb begin
    cfg_nxt           = '0;
    cfg_nxt.active    = port_active;
    cfg_nxt.cc_mode   = TCC_CC_PULL_DOWN;
    cfg_nxt.role      = TCC_ROLE_SINK;
    cfg_nxt.try_snk   = 1'b0;
    cfg_nxt.accessory = 1'b0;
    cfg_nxt.current   = TCC_CUR_DEFAULT;
    if (port_active) begin
      cfg_nxt.role    = ctrl_r.role;
      cfg_nxt.current = ctrl_r.current;
      case (ctrl_r.role)
        TCC_ROLE_SINK: begin
          // current is meaningless for a sink
          cfg_nxt.current   = TCC_CUR_DEFAULT;
          cfg_nxt.accessory = ctrl_r.accessory;
          cfg_nxt.cc_mode   = ctrl_r.accessory ?
                              TCC_CC_TOGGLE : TCC_CC_PULL_DOWN;
        end
        TCC_ROLE_SRC: begin
          cfg_nxt.cc_mode = TCC_CC_PULL_UP;
        end
        TCC_ROLE_DRP: begin
          cfg_nxt.cc_mode = TCC_CC_TOGGLE;
        end
        TCC_ROLE_DRP2: begin
          cfg_nxt.cc_mode = TCC_CC_TOGGLE;
          cfg_nxt.try_snk = ctrl_r.try_snk;
        end
        default: begin
          cfg_nxt.cc_mode = TCC_CC_PULL_DOWN;
        end
      endcase
    end
    // disabled by pin or power saving falls back to a pulled-down sink
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      port_cfg_out      <= '0;
      detect_enable_out <= 1'b0;
    end else begin
      port_cfg_out      <= cfg_nxt;
      detect_enable_out <= port_active;
    end
  end

  // ==========================================================================
  // interrupt and attach indicator outputs
  // power saving floats every output except cc and sda, so the int pull is dropped too
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      interrupt_request_out <= 1'b0;
      interrupt_oe_n_out    <= 1'b1;
      sda_out               <= 1'b0;
      attach_indicator_out  <= 1'b1;
    end else begin
      interrupt_request_out <= 1'b0;
      sda_out               <= 1'b0;
      interrupt_oe_n_out    <= ~((|event_r) & ~ctrl_r.mask &
                                 ~ctrl_r.save);
      attach_indicator_out  <= ~(port_active &&
                                 (cc_status_in == TCC_STAT_SRC_SHORT ||
                                  cc_status_in == TCC_STAT_SRC_CC1 ||
                                  cc_status_in == TCC_STAT_SRC_CC2));
    end
  end

endmodule // tcc_port_ctrl

// ===== hdl/tcc_pkg.sv
// package: register map, control fields and port configuration types
package tcc_pkg;

  // ==========================================================================
  // register indices (no pointer byte, transfers start at index 1)
  localparam logic [2:0] TCC_REG_FIRST  = 3'h1;
  localparam logic [2:0] TCC_REG_CTRL   = 3'h2;
  localparam logic [2:0] TCC_REG_EVENT  = 3'h3;
  localparam logic [2:0] TCC_REG_STATUS = 3'h4;
  localparam logic [2:0] TCC_REG_BEYOND = 3'h5;

  // ==========================================================================
  // control byte layout and reset value
  localparam int         TCC_CTRL_SAVE_BIT = 7;
  localparam int         TCC_CTRL_TRY_BIT  = 6;
  localparam int         TCC_CTRL_ACC_BIT  = 5;
  localparam int         TCC_CTRL_CUR_LSB  = 3;
  localparam int         TCC_CTRL_ROLE_LSB = 1;
  localparam int         TCC_CTRL_MASK_BIT = 0;
  localparam logic [7:0] TCC_CTRL_RESET    = 8'h00;

  // role field values
  localparam logic [1:0] TCC_ROLE_SINK = 2'h0;
  localparam logic [1:0] TCC_ROLE_SRC  = 2'h1;
  localparam logic [1:0] TCC_ROLE_DRP  = 2'h2;
  localparam logic [1:0] TCC_ROLE_DRP2 = 2'h3;

  // current advertisement values
  localparam logic [1:0] TCC_CUR_DEFAULT = 2'h0;
  localparam logic [1:0] TCC_CUR_1A5     = 2'h1;
  localparam logic [1:0] TCC_CUR_3A      = 2'h2;

  // cc status codes meaning "attached to a sink" (indicator pulled low)
  localparam logic [7:0] TCC_STAT_SRC_SHORT = 8'h04;
  localparam logic [7:0] TCC_STAT_SRC_CC1   = 8'h05;
  localparam logic [7:0] TCC_STAT_SRC_CC2   = 8'h06;

  // ==========================================================================
  // i2c byte framing
  localparam logic [3:0] TCC_BITS_PER_BYTE = 4'h8;
  localparam int         TCC_SYNC_WIDTH    = 6;

  // ==========================================================================
  // types
  typedef struct packed {
    logic       save;       // power saving, low-power disabled state
    logic       try_snk;    // 0 try.src, 1 try.snk
    logic       accessory;  // accessory detection as sink
    logic [1:0] current;    // advertised current
    logic [1:0] role;       // port role
    logic       mask;       // interrupt mask
  } tcc_ctrl_t;

  typedef enum logic [1:0] {
    TCC_CC_PULL_DOWN,
    TCC_CC_PULL_UP,
    TCC_CC_TOGGLE
  } tcc_cc_mode_t;

  typedef struct packed {
    logic         active;     // port logic enabled, not disabled
    tcc_cc_mode_t cc_mode;    // cc termination while unattached
    logic [1:0]   role;       // effective role
    logic         try_snk;    // try variant for dual role 2
    logic         accessory;  // accessory detection enabled
    logic [1:0]   current;    // effective advertised current
  } tcc_port_cfg_t;

endpackage

// ===== hdl/tcc_sync.sv
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps

module tcc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_in,  // core clock
  input  wire logic             reset_in,     // sync reset, active high
  input  wire logic [WIDTH-1:0] async_in,     // pins from outside domain
  output logic      [WIDTH-1:0] sync_out      // synchronised levels
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // tcc_sync

// ===== sim/tcc_port_ctrl_checker.sv
// checker: port configuration and pin relations of the control block
`timescale 1ns/1ps

module tcc_port_ctrl_checker
  import tcc_pkg::*;
(
  input wire logic          core_clk_in,           // core clock
  input wire logic          reset_in,              // sync reset
  input wire logic          scl_in,                // i2c clock pin
  input wire logic          sda_in,                // i2c data pin
  input wire logic          sda_out,               // sda drive level
  input wire logic          sda_oe_n_out,          // low: drive sda
  input wire logic          chip_disable_pin,      // high disables
  input wire logic [1:0]    role_strap_in,         // role strap
  input wire logic          addr_strap_in,         // address strap
  input wire logic [7:0]    event_set_in,          // event pulses
  input wire logic [7:0]    cc_status_in,          // cc status code
  input wire logic          interrupt_request_out, // int level
  input wire logic          interrupt_oe_n_out,    // low: pull int
  input wire logic          attach_indicator_out,  // low on sink
  input wire logic          detect_enable_out,     // monitor enable
  input wire tcc_pkg::tcc_port_cfg_t port_cfg_out  // port config
);
  // ==========================================================================
  // assertions
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  a_disable_forces_sink: assert property (chip_disable_pin [*6] |->
    !port_cfg_out.active && port_cfg_out.cc_mode == TCC_CC_PULL_DOWN)
    else $error("disable pin did not force sink");
  a_idle_pulls_low: assert property (!port_cfg_out.active |->
    port_cfg_out.cc_mode == TCC_CC_PULL_DOWN &&
    port_cfg_out.role == TCC_ROLE_SINK)
    else $error("inactive port not pulled low");
  a_detect_tracks: assert property ($stable(port_cfg_out.active) [*3] |->
    detect_enable_out == port_cfg_out.active)
    else $error("detect enable differs from port activity");
  a_source_pulls_up: assert property (port_cfg_out.active &&
    port_cfg_out.role == TCC_ROLE_SRC |-> port_cfg_out.cc_mode == TCC_CC_PULL_UP)
    else $error("source without pull-up");
  a_dual_toggles: assert property (port_cfg_out.active &&
    port_cfg_out.role[1] |-> port_cfg_out.cc_mode == TCC_CC_TOGGLE)
    else $error("dual role without toggling");
  a_sink_cc_mode: assert property (port_cfg_out.active &&
    port_cfg_out.role == TCC_ROLE_SINK |-> port_cfg_out.cc_mode ==
    (port_cfg_out.accessory ? TCC_CC_TOGGLE : TCC_CC_PULL_DOWN))
    else $error("sink cc mode wrong");
  a_sink_current: assert property (port_cfg_out.role == TCC_ROLE_SINK |->
    port_cfg_out.current == TCC_CUR_DEFAULT)
    else $error("sink advertises current");
  a_try_drp2_only: assert property (port_cfg_out.try_snk |->
    port_cfg_out.role == TCC_ROLE_DRP2)
    else $error("try variant outside dual role 2");
  a_attach_low: assert property ((port_cfg_out.active &&
    cc_status_in inside {8'h04, 8'h05, 8'h06}) [*3] |-> !attach_indicator_out)
    else $error("attach indicator not low");
  a_attach_high_off: assert property ((!port_cfg_out.active) [*3] |->
    attach_indicator_out)
    else $error("attach indicator low while inactive");
  a_reset_quiet: assert property (disable iff (1'b0) reset_in |=>
    sda_oe_n_out && interrupt_oe_n_out && !detect_enable_out)
    else $error("outputs active under reset");
  a_drive_levels: assert property (!sda_out && !interrupt_request_out)
    else $error("open-drain level not low");

  c_int_pulled: cover property (!interrupt_oe_n_out);
  c_attached: cover property (!attach_indicator_out);
  c_pin_off: cover property (chip_disable_pin && !port_cfg_out.active);
  c_try_snk: cover property (port_cfg_out.try_snk);
endmodule // tcc_port_ctrl_checker

// ===== sim/tcc_i2c_host.sv
// partner: i2c controller model with an 80 ns bit clock
`timescale 1ns/1ps

module tcc_i2c_host (
  output logic      scl_out,       // i2c clock, idles high
  output logic      sda_oe_n_out,  // low: pull sda low
  input  wire logic sda_in         // resolved sda level
);
  // ==========================================================================
  // bit level; scl stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end

  task automatic put_bit(input logic b, output logic seen);
    #20 sda_oe_n_out = b;
    #20 scl_out = 1'b1;
    #20 seen = sda_in;
    #20 scl_out = 1'b0;
  endtask

  task automatic start_frame();
    #20 sda_oe_n_out = 1'b1;
    #20 scl_out = 1'b1;
    #20 sda_oe_n_out = 1'b0;
    #40 scl_out = 1'b0;
  endtask

  task automatic stop_frame();
    #20 sda_oe_n_out = 1'b0;
    #20 scl_out = 1'b1;
    #20 sda_oe_n_out = 1'b1;
    #40;
  endtask

  // msb first, then the ninth bit for acknowledge
  task automatic xfer_byte(input logic [7:0] tx, input logic ack_in,
                           output logic [7:0] rx, output logic ack_seen);
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(ack_in, ack_seen);
  endtask
endmodule // tcc_i2c_host

// ===== sim/tcc_port_ctrl_tb.sv
// testbench: register access, role codes, disable and power saving
`timescale 1ns/1ps

module tcc_port_ctrl_tb;
  import tcc_pkg::*;
  localparam logic [5:0] ADDR_HI = 6'h1d;
  logic          core_clk_in;
  logic          reset_in;
  logic          scl_w;
  logic          host_oe_n;
  wire           sda_w;
  logic          sda_out;
  logic          sda_oe_n_out;
  logic          chip_disable_pin;
  logic [1:0]    role_strap_in;
  logic          addr_strap_in;
  logic [7:0]    event_set_in;
  logic [7:0]    cc_status_in;
  logic          int_lvl;
  logic          int_oe_n;
  logic          attach_n;
  logic          detect_en;
  tcc_port_cfg_t cfg;
  int            err_total;
  int            comparisons;
  logic [7:0]    rd [1:4];
  logic          ack;
  logic [7:0]    codes [14] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h0a, 8'h0c,
    8'h0e, 8'h12, 8'h14, 8'h16, 8'h46, 8'h4e, 8'h56, 8'h20};

  // pull-up on sda, either party may pull low
  assign sda_w = host_oe_n & (sda_oe_n_out | sda_out);

  tcc_port_ctrl #(.ADDR_HIGH(ADDR_HI)) dut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .scl_in(scl_w),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .chip_disable_pin(chip_disable_pin), .role_strap_in(role_strap_in),
    .addr_strap_in(addr_strap_in), .event_set_in(event_set_in),
    .cc_status_in(cc_status_in), .interrupt_request_out(int_lvl),
    .interrupt_oe_n_out(int_oe_n), .attach_indicator_out(attach_n),
    .detect_enable_out(detect_en), .port_cfg_out(cfg));

  tcc_i2c_host host (.scl_out(scl_w), .sda_oe_n_out(host_oe_n),
                     .sda_in(sda_w));

  // ==========================================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // every frame restarts at register 1, no pointer byte
  task automatic frame(input logic rnw, input logic [7:0] ctl,
                       input logic [6:0] adr);
    logic [7:0] junk;
    logic       a;
    host.start_frame();
    host.xfer_byte({adr, rnw}, 1'b1, junk, ack);
    if (ack === 1'b0) begin
      for (int i = 1; i <= 4; i++) begin
        if (rnw) host.xfer_byte(8'hff, i == 4, rd[i], a);
        else if (i <= 2) host.xfer_byte(i == 2 ? ctl : 8'h5a, 1'b1, junk, a);
      end
    end
    host.stop_frame();
    tick(8);
  endtask

  task automatic wr(input logic [7:0] v);
    frame(1'b0, v, {ADDR_HI, addr_strap_in});
  endtask

  task automatic rd_all();
    frame(1'b1, 8'h00, {ADDR_HI, addr_strap_in});
  endtask

  task automatic pulse(input logic [7:0] ev);
    event_set_in = ev;
    tick(1);
    event_set_in = 8'h00;
    tick(4);
  endtask

  function automatic tcc_port_cfg_t exp_cfg(input logic [7:0] v);
    tcc_port_cfg_t c;
    c.active    = 1'b1;
    c.role      = v[2:1];
    c.try_snk   = (v[2:1] == TCC_ROLE_DRP2) & v[6];
    c.accessory = v[5];
    c.current   = (v[2:1] == TCC_ROLE_SINK) ? TCC_CUR_DEFAULT : v[4:3];
    c.cc_mode   = (v[2:1] == TCC_ROLE_SRC) ? TCC_CC_PULL_UP :
                  (v[2:1] == TCC_ROLE_SINK && !v[5]) ? TCC_CC_PULL_DOWN :
                  TCC_CC_TOGGLE;
    return c;
  endfunction

  task automatic report_and_stop();
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================================
  // clock, watchdog, tests
  initial begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  initial begin
    #400000;
    err_total++;
    report_and_stop();
  end

  initial begin
    err_total = 0;
    comparisons = 0;
    reset_in = 1'b1;
    chip_disable_pin = 1'b0;
    role_strap_in = 2'b10;
    addr_strap_in = 1'b1;
    event_set_in = 8'h00;
    cc_status_in = 8'h00;
    tick(20);
    reset_in = 1'b0;
    tick(10);
    rd_all();
    chk("reg1", 16'h00, rd[1]);
    chk("reg2", 16'h04, rd[2]);
    chk("reg4", 16'h00, rd[4]);
    chk("detect", 16'h1, detect_en);
    wr(8'h01);
    chk("int_idle", 16'h1, int_oe_n);
    frame(1'b0, 8'h13, {ADDR_HI, ~addr_strap_in});
    chk("addr_nack", 16'h1, ack);
    foreach (codes[k]) for (int m = 0; m < 2; m++) begin
      wr(codes[k] | m);
      rd_all();
      chk("reg2", codes[k] | m, rd[2]);
      chk("cfg", exp_cfg(codes[k] | m), cfg);
    end
    wr(8'h04);
    cc_status_in = 8'h05;
    pulse(8'h01);
    chk("int_on", 16'h0, int_oe_n);
    chk("attach", 16'h0, attach_n);
    rd_all();
    chk("reg3", 16'h01, rd[3]);
    chk("reg4", 16'h05, rd[4]);
    rd_all();
    chk("reg3_clr", 16'h00, rd[3]);
    chk("int_off", 16'h1, int_oe_n);
    wr(8'h05);
    pulse(8'h02);
    chk("int_mask", 16'h1, int_oe_n);
    chip_disable_pin = 1'b1;
    tick(8);
    chk("cfg_pin", 16'h0, {11'h0, cfg.active, cfg.cc_mode, cfg.role});
    chk("detect_pin", 16'h0, detect_en);
    chk("attach_pin", 16'h1, attach_n);
    rd_all();
    chk("reg3_pin", 16'h02, rd[3]);
    chip_disable_pin = 1'b0;
    tick(8);
    chk("cfg_back", exp_cfg(8'h05), cfg);
    wr(8'h81);
    chk("cfg_save", 16'h0, {11'h0, cfg.active, cfg.cc_mode, cfg.role});
    chk("int_save", 16'h1, int_oe_n);
    rd_all();
    chk("reg2_save", 16'h81, rd[2]);
    wr(8'h46);
    chk("cfg_resume", exp_cfg(8'h46), cfg);
    role_strap_in = 2'b01;
    reset_in = 1'b1;
    tick(3);
    reset_in = 1'b0;
    tick(10);
    rd_all();
    chk("reg2_rst", 16'h02, rd[2]);
    chk("reg3_rst", 16'h00, rd[3]);
    report_and_stop();
  end
endmodule // tcc_port_ctrl_tb

bind tcc_port_ctrl tcc_port_ctrl_checker chk_i (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
  .chip_disable_pin(chip_disable_pin), .role_strap_in(role_strap_in),
  .addr_strap_in(addr_strap_in), .event_set_in(event_set_in),
  .cc_status_in(cc_status_in), .interrupt_request_out(interrupt_request_out),
  .interrupt_oe_n_out(interrupt_oe_n_out),
  .attach_indicator_out(attach_indicator_out),
  .detect_enable_out(detect_enable_out), .port_cfg_out(port_cfg_out));
